// ==== opc_defines.vh ====
`ifndef OPC_DEFINES_VH
`define OPC_DEFINES_VH

// Clock rate, 64 bits wide so derived counts cannot overflow
`define OPC_CLK_HZ            64'h000000000EE6B280
// Times in their own units
`define OPC_IDLE_MIN          5
`define OPC_MAINS_LOSS_S      10
`define OPC_LONG_PRESS_S      3
`define OPC_EDIT_WIN_S        10
`define OPC_LAMP_HALF_S       1
`define OPC_REPEAT_MS         500
`define OPC_DEBOUNCE_MS       10
// Derived cycle counts
`define OPC_IDLE_CYC          (`OPC_IDLE_MIN * 60 * `OPC_CLK_HZ)
`define OPC_MAINS_LOSS_CYC    (`OPC_MAINS_LOSS_S * `OPC_CLK_HZ)
`define OPC_LONG_PRESS_CYC    (`OPC_LONG_PRESS_S * `OPC_CLK_HZ)
`define OPC_EDIT_WIN_CYC      (`OPC_EDIT_WIN_S * `OPC_CLK_HZ)
`define OPC_LAMP_HALF_CYC     (`OPC_LAMP_HALF_S * `OPC_CLK_HZ)
`define OPC_REPEAT_CYC        (`OPC_REPEAT_MS * (`OPC_CLK_HZ / 1000))
`define OPC_DEBOUNCE_CYC      (`OPC_DEBOUNCE_MS * (`OPC_CLK_HZ / 1000))
// Lamp test flashes
`define OPC_LAMP_FLASHES      3
// Battery thresholds in millivolts
`define OPC_BATT_LOW_MV       20000
`define OPC_BATT_DROP_MV      2000
// Screen numbers
`define OPC_SCREEN_FIRST      1
`define OPC_SCREEN_LAST       39
// Key index within key vector
`define OPC_KEY_TRIP          0
`define OPC_KEY_CLOSE         1
`define OPC_KEY_NEXT          2
`define OPC_KEY_BACK          3
`define OPC_KEY_RESET         4
`define OPC_KEY_EDIT          5
`define OPC_KEY_TAG           6
`define OPC_NKEYS             7

`endif

// ==== opc_key.v ====
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Key synchroniser, debounce and hold timer
// -----------------------------------------------------------------
module opc_key #(
	parameter DEB_CYC  = 2500000,
	parameter LONG_CYC = 750000000,
	parameter RPT_CYC  = 125000000
) (
	input  wire ref_clk_i,
	input  wire sys_rst_i,
	input  wire key_i,
	output reg  press_o,
	output reg  short_o,
	output reg  long_o,
	output reg  repeat_o,
	output reg  held_o
);
	reg        sync1;
	reg        sync2;
	reg [31:0] deb_cnt;
	reg [31:0] hold_cnt;
	reg [31:0] rpt_cnt;
	reg        long_done;

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1     <= 1'b0;
			sync2     <= 1'b0;
			deb_cnt   <= 32'h0;
			hold_cnt  <= 32'h0;
			rpt_cnt   <= 32'h0;
			long_done <= 1'b0;
			held_o    <= 1'b0;
			press_o   <= 1'b0;
			short_o   <= 1'b0;
			long_o    <= 1'b0;
			repeat_o  <= 1'b0;
		end else begin
			sync1    <= key_i;
			sync2    <= sync1;
			press_o  <= 1'b0;
			short_o  <= 1'b0;
			long_o   <= 1'b0;
			repeat_o <= 1'b0;
			if (sync2 == held_o) begin
				deb_cnt <= 32'h0;
			end else if (deb_cnt >= DEB_CYC - 1) begin
				deb_cnt <= 32'h0;
				held_o  <= sync2;
				if (sync2) begin
					press_o <= 1'b1;
				end else if (!long_done) begin
					short_o <= 1'b1;
				end
			end else begin
				deb_cnt <= deb_cnt + 32'h1;
			end
			if (!held_o) begin
				hold_cnt  <= 32'h0;
				rpt_cnt   <= 32'h0;
				long_done <= 1'b0;
			end else begin
				if (!long_done && hold_cnt >= LONG_CYC - 1) begin
					long_o    <= 1'b1;
					long_done <= 1'b1;
				end else if (!long_done) begin
					hold_cnt <= hold_cnt + 32'h1;
				end
				if (rpt_cnt >= RPT_CYC - 1) begin
					rpt_cnt  <= 32'h0;
					repeat_o <= 1'b1;
				end else begin
					rpt_cnt <= rpt_cnt + 32'h1;
				end
			end
		end
	end
endmodule

// ==== opc_timer.v ====
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Restartable countdown, done level when expired
// -----------------------------------------------------------------
module opc_timer #(
	parameter CYC = 1000
) (
	input  wire ref_clk_i,
	input  wire sys_rst_i,
	input  wire restart_i,
	input  wire hold_i,
	output reg  done_o
);
	reg [39:0] cnt;

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt    <= 40'h0;
			done_o <= 1'b0;
		end else if (restart_i || hold_i) begin
			cnt    <= 40'h0;
			done_o <= 1'b0;
		end else if (cnt >= CYC - 1) begin
			done_o <= 1'b1;
		end else begin
			cnt <= cnt + 40'h1;
		end
	end
endmodule

// ==== opc_panel.v ====
`timescale 1ns/1ps
`include "opc_defines.vh"
// Notes on behaviour
// - After five idle minutes all lamps off except tag and position lamps.
// - Idle state keeps text but drops backlight; any key restores lamps.
// - Health lamp lit only while diagnostics report no fault.
// - Mains lamp on with ac; off after ac absent over ten seconds.
// - Above-pickup lamp lit when any channel current exceeds its minimum trip.
// - Battery lamp when voltage below 20 V or test drop of 2 V.
// - Failed manual battery test latches battery lamp until a passing test.
// - Mechanism fault lamp on failed trip or close; clears at correct state.
// - On overcurrent trip, latch targets of channels above pickup.
// - Targets clear after successful close with auto reset, else by reset key.
// - Each bushing voltage lamp follows its voltage detect input.
// - Closed and open lamps follow sensed mechanism position.
// - Lockout lamp when open with no sequence, or handle down.
// - Trip failure flashes fault, open, closed and lockout lamps.
// - Trip key commands open and lockout.
// - Close key homes sequence and closes after delay; no effect if closed.
// - Close from lockout starts cold load pickup if enabled and unblocked.
// - Next and back step screens; holding next repeats twice per second.
// - Short reset clears targets and currents; long clears only min/max and trip failure.
// - Short edit press opens ten second window for one switch change.
// - Long edit press flashes lamps three times, one second each phase.
// - During lamp test only trip, close and tag keys act.
module opc_panel #(
	parameter IDLE_CYC  = `OPC_IDLE_CYC,
	parameter MAINS_CYC = `OPC_MAINS_LOSS_CYC,
	parameter LONG_CYC  = `OPC_LONG_PRESS_CYC,
	parameter EDIT_CYC  = `OPC_EDIT_WIN_CYC,
	parameter LAMP_CYC  = `OPC_LAMP_HALF_CYC,
	parameter RPT_CYC   = `OPC_REPEAT_CYC,
	parameter DEB_CYC   = `OPC_DEBOUNCE_CYC
) (
	input  wire        ref_clk_i,
	input  wire        sys_rst_i,
	input  wire [6:0]  keys_i,
	input  wire [8:0]  func_sw_i,
	input  wire        diag_fault_i,
	input  wire        ac_sense_i,
	input  wire [4:0]  above_pickup_i,
	input  wire [15:0] batt_mv_i,
	input  wire        batt_test_done_i,
	input  wire        batt_test_pass_i,
	input  wire        batt_test_drop_i,
	input  wire        mech_fail_i,
	input  wire        oc_trip_i,
	input  wire        close_ok_i,
	input  wire        auto_reset_en_i,
	input  wire [2:0]  bush_volt_i,
	input  wire        rec_closed_i,
	input  wire        seq_active_i,
	input  wire        handle_down_i,
	input  wire        trip_fail_i,
	input  wire        cold_load_pickup_en_i,
	input  wire        cold_load_pickup_blocked_i,
	output reg         health_led_o,
	output reg         mains_indicator_o,
	output reg         pickup_led_o,
	output reg         batt_led_o,
	output reg         mechanism_fault_indicator_o,
	output reg  [4:0]  target_led_o,
	output reg  [2:0]  bush_led_o,
	output reg         closed_led_o,
	output reg         open_led_o,
	output reg         lockout_led_o,
	output reg         tag_led_o,
	output reg         backlight_o,
	output reg         trip_cmd_o,
	output reg         close_cmd_o,
	output reg         lockout_cmd_o,
	output reg         cold_load_pickup_o,
	output reg  [5:0]  screen_o,
	output reg         clear_fault_amps_o,
	output reg         clear_minmax_o,
	output reg         clear_trip_fail_o,
	output reg         edit_mode_o,
	output reg  [8:0]  func_sw_toggle_o,
	output reg         lamp_test_o
);
	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	reg [15:0] sa;
	reg [15:0] sb;
	reg [8:0]  sw_a;
	reg [8:0]  sw_b;
	reg [8:0]  sw_prev;
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sa   <= 16'h0;
			sb   <= 16'h0;
			sw_a <= 9'h0;
			sw_b <= 9'h0;
		end else begin
			sa   <= {diag_fault_i, ac_sense_i, above_pickup_i, bush_volt_i, rec_closed_i,
				seq_active_i, handle_down_i, trip_fail_i, mech_fail_i, oc_trip_i};
			sb   <= sa;
			sw_a <= func_sw_i;
			sw_b <= sw_a;
		end
	end
	wire       s_diag   = sb[15];
	wire       s_ac     = sb[14];
	wire [4:0] s_pick   = sb[13:9];
	wire [2:0] s_bush   = sb[8:6];
	wire       s_closed = sb[5];
	wire       s_seq    = sb[4];
	wire       s_handle = sb[3];
	wire       s_tfail  = sb[2];
	wire       s_mfail  = sb[1];
	wire       s_octrip = sb[0];

	// -----------------------------------------------------------------
	// Keys
	// -----------------------------------------------------------------
	wire [6:0] k_press;
	wire [6:0] k_short;
	wire [6:0] k_long;
	wire [6:0] k_rpt;
	wire [6:0] k_held;
	genvar g;
	generate
		for (g = 0; g < `OPC_NKEYS; g = g + 1) begin : g_key
			opc_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC), .RPT_CYC(RPT_CYC)) u_key (
				.ref_clk_i (ref_clk_i),
				.sys_rst_i (sys_rst_i),
				.key_i     (keys_i[g]),
				.press_o   (k_press[g]),
				.short_o   (k_short[g]),
				.long_o    (k_long[g]),
				.repeat_o  (k_rpt[g]),
				.held_o    (k_held[g])
			);
		end
	endgenerate
	wire activity = |(k_press | k_short | k_long | k_rpt);

	// -----------------------------------------------------------------
	// Timers
	// -----------------------------------------------------------------
	wire idle;
	wire mains_gone;
	wire edit_exp;
	reg  lamp_on;
	opc_timer #(.CYC(IDLE_CYC)) u_idle (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.restart_i (activity),
		.hold_i    (1'b0),
		.done_o    (idle)
	);
	opc_timer #(.CYC(MAINS_CYC)) u_mains (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.restart_i (1'b0),
		.hold_i    (s_ac),
		.done_o    (mains_gone)
	);
	opc_timer #(.CYC(EDIT_CYC)) u_edit (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.restart_i (1'b0),
		.hold_i    (!edit_mode_o),
		.done_o    (edit_exp)
	);

	// -----------------------------------------------------------------
	// Lamp test sequencer
	// -----------------------------------------------------------------
	localparam LT_IDLE = 1'b0;
	localparam LT_RUN  = 1'b1;
	reg        lt_state;
	reg [39:0] lt_cnt;
	reg [2:0]  lt_phase;
	wire       lt_busy = (lt_state == LT_RUN);
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lt_state <= LT_IDLE;
			lt_cnt   <= 40'h0;
			lt_phase <= 3'h0;
			lamp_on  <= 1'b0;
		end else begin
			case (lt_state)
				LT_IDLE: begin
					// long edit press starts lamp test
					if (k_long[`OPC_KEY_EDIT]) begin
						lt_state <= LT_RUN;
						lt_cnt   <= 40'h0;
						lt_phase <= 3'h0;
						lamp_on  <= 1'b1;
					end
				end
				LT_RUN: begin
					// one second on, one second off, three times
					if (lt_cnt >= LAMP_CYC - 1) begin
						lt_cnt   <= 40'h0;
						lt_phase <= lt_phase + 3'h1;
						lamp_on  <= ~lamp_on;
						if (lt_phase == 3'h5) begin
							lt_state <= LT_IDLE;
							lamp_on  <= 1'b0;
						end
					end else begin
						lt_cnt <= lt_cnt + 40'h1;
					end
				end
				default: lt_state <= LT_IDLE;
			endcase
		end
	end
	// next, back, reset and edit keys gated off during lamp test
	wire kp_ok = !lt_busy;

	// -----------------------------------------------------------------
	// Latched status
	// -----------------------------------------------------------------
	reg  [4:0] targets;
	reg        batt_latch;
	reg        mfault;
	reg        tfail_seen;
	reg        flash;
	reg [27:0] flash_cnt;
	wire       is_lockout = (!s_closed && !s_seq) || s_handle;
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			targets    <= 5'h0;
			batt_latch <= 1'b0;
			mfault     <= 1'b0;
			tfail_seen <= 1'b0;
			flash      <= 1'b0;
			flash_cnt  <= 28'h0;
		end else begin
			flash_cnt <= flash_cnt + 28'h1;
			if (flash_cnt == 28'h0)
				flash <= ~flash;
			if (s_octrip)
				targets <= s_pick;
			// auto reset on close or reset key
			else if ((close_ok_i && auto_reset_en_i) || (kp_ok && k_short[`OPC_KEY_RESET]))
				targets <= 5'h0;
			if (batt_test_done_i)
				batt_latch <= !batt_test_pass_i;
			if (s_mfail)
				mfault <= 1'b1;
			else if (s_closed == close_cmd_o)
				mfault <= 1'b0;
			if (s_tfail)
				tfail_seen <= 1'b1;
			else if (kp_ok && k_long[`OPC_KEY_RESET])
				tfail_seen <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Commands, navigation, edit window and outputs
	// -----------------------------------------------------------------
	wire ind_on = !idle;
	reg  edit_used;
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			health_led_o                <= 1'b0;
			mains_indicator_o           <= 1'b0;
			pickup_led_o                <= 1'b0;
			batt_led_o                  <= 1'b0;
			mechanism_fault_indicator_o <= 1'b0;
			target_led_o                <= 5'h0;
			bush_led_o                  <= 3'h0;
			closed_led_o                <= 1'b0;
			open_led_o                  <= 1'b0;
			lockout_led_o               <= 1'b0;
			tag_led_o                   <= 1'b0;
			backlight_o                 <= 1'b1;
			trip_cmd_o                  <= 1'b0;
			close_cmd_o                 <= 1'b0;
			lockout_cmd_o               <= 1'b0;
			cold_load_pickup_o          <= 1'b0;
			screen_o                    <= 6'h01;
			clear_fault_amps_o          <= 1'b0;
			clear_minmax_o              <= 1'b0;
			clear_trip_fail_o           <= 1'b0;
			edit_mode_o                 <= 1'b0;
			func_sw_toggle_o            <= 9'h0;
			lamp_test_o                 <= 1'b0;
			edit_used                   <= 1'b0;
			sw_prev                     <= 9'h0;
		end else begin
			trip_cmd_o         <= 1'b0;
			close_cmd_o        <= close_cmd_o;
			cold_load_pickup_o <= 1'b0;
			clear_fault_amps_o <= 1'b0;
			clear_minmax_o     <= 1'b0;
			clear_trip_fail_o  <= 1'b0;
			func_sw_toggle_o   <= 9'h0;
			sw_prev            <= sw_b;
			lamp_test_o        <= lt_busy;
			if (k_press[`OPC_KEY_TRIP]) begin
				trip_cmd_o    <= 1'b1;
				close_cmd_o   <= 1'b0;
				lockout_cmd_o <= 1'b1;
			// close only when open; delay kept by sequencer
			end else if (k_press[`OPC_KEY_CLOSE] && !s_closed) begin
				close_cmd_o   <= 1'b1;
				lockout_cmd_o <= 1'b0;
				// cold load on press from lockout
				if (is_lockout && cold_load_pickup_en_i && !cold_load_pickup_blocked_i)
					cold_load_pickup_o <= 1'b1;
			end
			if (k_press[`OPC_KEY_TAG])
				tag_led_o <= ~tag_led_o;
			if (kp_ok && (k_press[`OPC_KEY_NEXT] || k_rpt[`OPC_KEY_NEXT]))
				screen_o <= (screen_o == `OPC_SCREEN_LAST) ? 6'h01 : screen_o + 6'h01;
			else if (kp_ok && (k_press[`OPC_KEY_BACK] || k_rpt[`OPC_KEY_BACK]))
				screen_o <= (screen_o == `OPC_SCREEN_FIRST) ? 6'h27 : screen_o - 6'h01;
			if (kp_ok && k_short[`OPC_KEY_RESET])
				clear_fault_amps_o <= 1'b1;
			if (kp_ok && k_long[`OPC_KEY_RESET]) begin
				clear_minmax_o    <= 1'b1;
				clear_trip_fail_o <= 1'b1;
			end
			if (kp_ok && k_short[`OPC_KEY_EDIT]) begin
				edit_mode_o <= 1'b1;
				edit_used   <= 1'b0;
			end else if (edit_exp) begin
				edit_mode_o <= 1'b0;
			end else if (edit_mode_o && !edit_used && |(sw_b & ~sw_prev)) begin
				// Lowest switch only when several rise together
				func_sw_toggle_o <= (sw_b & ~sw_prev) & ~((sw_b & ~sw_prev) - 9'h001);
				edit_used        <= 1'b1;
				edit_mode_o      <= 1'b0;
			end
			backlight_o <= ind_on;
			if (lt_busy) begin
				health_led_o                <= lamp_on;
				mains_indicator_o           <= lamp_on;
				pickup_led_o                <= lamp_on;
				batt_led_o                  <= lamp_on;
				mechanism_fault_indicator_o <= lamp_on;
				target_led_o                <= {5{lamp_on}};
				bush_led_o                  <= {3{lamp_on}};
				closed_led_o                <= lamp_on;
				open_led_o                  <= lamp_on;
				lockout_led_o               <= lamp_on;
			end else begin
				health_led_o      <= ind_on && !s_diag;
				mains_indicator_o <= ind_on && !mains_gone;
				pickup_led_o      <= ind_on && |s_pick;
				batt_led_o <= ind_on && ((batt_mv_i < `OPC_BATT_LOW_MV) || batt_test_drop_i
					|| batt_latch);
				mechanism_fault_indicator_o <= ind_on && (tfail_seen ? flash : mfault);
				target_led_o <= ind_on ? targets : 5'h0;
				bush_led_o   <= ind_on ? s_bush : 3'h0;
				// position lamps stay on when idle
				closed_led_o  <= s_closed && !(tfail_seen && !flash);
				open_led_o    <= !s_closed && !(tfail_seen && !flash);
				lockout_led_o <= ind_on && is_lockout && !(tfail_seen && !flash);
			end
		end
	end
endmodule

// ==== opc_panel_assertions.sv ====
`timescale 1ns/1ps
// ----
// Panel port checks
// ----
module opc_panel_chk #(
	parameter EDIT_CYC = 100
) (
	input wire       ref_clk_i,
	input wire       sys_rst_i,
	input wire       diag_fault_i,
	input wire       ac_sense_i,
	input wire [4:0] above_pickup_i,
	input wire       rec_closed_i,
	input wire       health_led_o,
	input wire       mains_indicator_o,
	input wire       pickup_led_o,
	input wire [4:0] target_led_o,
	input wire [2:0] bush_led_o,
	input wire       backlight_o,
	input wire       trip_cmd_o,
	input wire       close_cmd_o,
	input wire       lockout_cmd_o,
	input wire [5:0] screen_o,
	input wire       edit_mode_o,
	input wire [8:0] func_sw_toggle_o,
	input wire       clear_minmax_o,
	input wire       lamp_test_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	reg [7:0] edit_cnt;
	// Length of the current edit window
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			edit_cnt <= 8'h00;
		else if (edit_mode_o)
			edit_cnt <= edit_cnt + 8'h01;
		else
			edit_cnt <= 8'h00;
	end
	trip_pulse_a: assert property (trip_cmd_o |=> !trip_cmd_o)
		else $error("trip command longer than one cycle");
	trip_lockout_a: assert property (trip_cmd_o |-> ##[0:2] lockout_cmd_o)
		else $error("trip without lockout");
	health_fault_a: assert property ((diag_fault_i && !lamp_test_o) [*6] |-> !health_led_o)
		else $error("health lamp lit with fault");
	pickup_quiet_a: assert property
		((above_pickup_i == 5'h00 && !lamp_test_o) [*6] |-> !pickup_led_o)
		else $error("pickup lamp lit without current");
	idle_dark_a: assert property (!backlight_o [*2] ##0 !lamp_test_o |->
		!health_led_o && !mains_indicator_o && !pickup_led_o && target_led_o == 5'h00
		&& bush_led_o == 3'h0) else $error("lamp lit while idle");
	mains_on_a: assert property
		((ac_sense_i && backlight_o && !lamp_test_o) [*6] |-> mains_indicator_o)
		else $error("mains lamp off with ac present");
	close_refused_a: assert property (rec_closed_i [*8] |-> !$rose(close_cmd_o))
		else $error("close request while closed");
	edit_len_a: assert property (edit_cnt <= EDIT_CYC + 2)
		else $error("edit window too long");
	toggle_edit_a: assert property (func_sw_toggle_o != 9'h000 |->
		$onehot(func_sw_toggle_o) && ($past(edit_mode_o) || $past(edit_mode_o, 2)))
		else $error("switch change outside edit window");
	screen_range_a: assert property (screen_o >= 6'h01 && screen_o <= 6'h27)
		else $error("screen number out of range");
	minmax_pulse_a: assert property (clear_minmax_o |=> !clear_minmax_o)
		else $error("min max clear longer than one cycle");
	cover property ($rose(lamp_test_o));
	cover property ($rose(edit_mode_o));
	cover property ($fell(backlight_o));
endmodule
bind opc_panel opc_panel_chk #(.EDIT_CYC(EDIT_CYC)) opc_panel_chk_i (.*);

// ==== opc_operator.sv ====
`timescale 1ns/1ps
// ----
// Operator at the keys
// ----
module opc_operator #(
	parameter DEB_CYC = 4
) (
	input  wire       ref_clk_i,
	output reg  [6:0] keys_o,
	output reg  [8:0] func_sw_o
);
	initial begin
		keys_o = 7'h00;
		func_sw_o = 9'h000;
	end
	// Contact bounce before the held press
	task press(input integer k, input integer n);
		begin
			@(posedge ref_clk_i) keys_o[k] <= 1'b1;
			@(posedge ref_clk_i) keys_o[k] <= 1'b0;
			@(posedge ref_clk_i) keys_o[k] <= 1'b1;
			repeat (n) @(posedge ref_clk_i);
			keys_o[k] <= 1'b0;
			repeat (DEB_CYC + 8) @(posedge ref_clk_i);
			#1;
		end
	endtask
	task flip(input integer s);
		begin
			@(posedge ref_clk_i) func_sw_o[s] <= ~func_sw_o[s];
			repeat (DEB_CYC + 8) @(posedge ref_clk_i);
			#1;
		end
	endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam IDLE = 200, MAINS = 50, LONG = 60, EDIT = 100, LAMP = 20, RPT = 30, DEB = 4;
	reg ref_clk_i = 1'b0, sys_rst_i = 1'b1, diag_fault_i = 1'b0, ac_sense_i = 1'b1;
	reg [4:0] above_pickup_i = 5'h00;
	reg [15:0] batt_mv_i = 16'h5DC0;
	reg batt_test_done_i = 1'b0, batt_test_pass_i = 1'b0, batt_test_drop_i = 1'b0;
	reg mech_fail_i = 1'b0, oc_trip_i = 1'b0, close_ok_i = 1'b0, auto_reset_en_i = 1'b0;
	reg [2:0] bush_volt_i = 3'h0;
	reg rec_closed_i = 1'b0, seq_active_i = 1'b0, handle_down_i = 1'b0, trip_fail_i = 1'b0;
	reg cold_load_pickup_en_i = 1'b0, cold_load_pickup_blocked_i = 1'b0, clr = 1'b0, pk_q = 1'b0;
	wire [6:0] keys_i;
	wire [8:0] func_sw_i, func_sw_toggle_o;
	wire [4:0] target_led_o;
	wire [2:0] bush_led_o;
	wire [5:0] screen_o;
	wire health_led_o, mains_indicator_o, pickup_led_o, batt_led_o, mechanism_fault_indicator_o;
	wire closed_led_o, open_led_o, lockout_led_o, tag_led_o, backlight_o, trip_cmd_o;
	wire close_cmd_o, lockout_cmd_o, cold_load_pickup_o, clear_fault_amps_o, clear_minmax_o;
	wire clear_trip_fail_o, edit_mode_o, lamp_test_o;
	reg [13:0] seen = 14'h0000;
	integer mismatches = 0, checked = 0, flashes = 0, i;
	opc_operator #(.DEB_CYC(DEB)) opc_operator_i (.ref_clk_i(ref_clk_i), .keys_o(keys_i),
		.func_sw_o(func_sw_i));
	opc_panel #(.IDLE_CYC(IDLE), .MAINS_CYC(MAINS), .LONG_CYC(LONG), .EDIT_CYC(EDIT),
		.LAMP_CYC(LAMP), .RPT_CYC(RPT), .DEB_CYC(DEB)) opc_panel_i (.*);
	always #2 ref_clk_i = ~ref_clk_i;
	// Collect command and clear pulses
	always @(posedge ref_clk_i) begin
		seen <= clr ? 14'h0000 : seen | {clear_trip_fail_o, clear_minmax_o, clear_fault_amps_o,
			cold_load_pickup_o, trip_cmd_o, func_sw_toggle_o};
		pk_q <= pickup_led_o;
		if (lamp_test_o && pickup_led_o && !pk_q)
			flashes = flashes + 1;
	end
	task wt(input integer n);
		begin
			repeat (n) @(posedge ref_clk_i);
			#1;
		end
	endtask
	task clr_seen;
		begin
			@(posedge ref_clk_i) clr <= 1'b1;
			@(posedge ref_clk_i) clr <= 1'b0;
		end
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task trip_pulse(input logic [4:0] amps);
		begin
			@(posedge ref_clk_i) above_pickup_i <= amps;
			oc_trip_i <= 1'b1;
			wt(4);
			@(posedge ref_clk_i) oc_trip_i <= 1'b0;
			above_pickup_i <= 5'h00;
			wt(8);
		end
	endtask
	task ok_pulse;
		begin
			@(posedge ref_clk_i) close_ok_i <= 1'b1;
			@(posedge ref_clk_i) close_ok_i <= 1'b0;
			wt(6);
		end
	endtask
	task finish_test;
		begin
			$display("checked %0d mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		wt(3);
		check(16'({backlight_o, screen_o}), 16'h0041);
		@(posedge ref_clk_i) sys_rst_i <= 1'b0;
		wt(8);
		check(16'({health_led_o, mains_indicator_o, open_led_o, closed_led_o,
			lockout_led_o}), 16'h001D);
		@(posedge ref_clk_i) diag_fault_i <= 1'b1;
		wt(8);
		check(16'(health_led_o), 16'h0000);
		@(posedge ref_clk_i) seq_active_i <= 1'b1;
		diag_fault_i <= 1'b0;
		wt(6);
		check(16'({lockout_led_o, health_led_o}), 16'h0001);
		@(posedge ref_clk_i) handle_down_i <= 1'b1;
		wt(6);
		check(16'(lockout_led_o), 16'h0001);
		@(posedge ref_clk_i) handle_down_i <= 1'b0;
		opc_operator_i.press(2, 10);
		check(16'(screen_o), 16'h0002);
		opc_operator_i.press(3, 10);
		opc_operator_i.press(3, 10);
		check(16'(screen_o), 16'h0027);
		opc_operator_i.press(2, 100);
		check(16'(screen_o >= 6'h03 && screen_o <= 6'h05), 16'h0001);
		@(posedge ref_clk_i) bush_volt_i <= 3'h5;
		above_pickup_i <= 5'h12;
		wt(8);
		check(16'({bush_led_o, pickup_led_o}), 16'h000B);
		trip_pulse(5'h12);
		check(16'(target_led_o), 16'h0012);
		clr_seen;
		opc_operator_i.press(4, 10);
		check(16'({seen[12:11], target_led_o}), 16'h0020);
		@(posedge ref_clk_i) trip_fail_i <= 1'b1;
		@(posedge ref_clk_i) trip_fail_i <= 1'b0;
		wt(8);
		check(16'(mechanism_fault_indicator_o), 16'h0001);
		clr_seen;
		opc_operator_i.press(4, LONG + 10);
		check(16'({seen[13:12], mechanism_fault_indicator_o}), 16'h0006);
		trip_pulse(5'h01);
		ok_pulse;
		check(16'(target_led_o), 16'h0001);
		@(posedge ref_clk_i) auto_reset_en_i <= 1'b1;
		ok_pulse;
		check(16'(target_led_o), 16'h0000);
		@(posedge ref_clk_i) seq_active_i <= 1'b0;
		clr_seen;
		opc_operator_i.press(0, 10);
		check(16'({seen[9], lockout_cmd_o, close_cmd_o}), 16'h0006);
		@(posedge ref_clk_i) cold_load_pickup_blocked_i <= 1'b1;
		cold_load_pickup_en_i <= 1'b1;
		clr_seen;
		opc_operator_i.press(1, 10);
		check(16'({seen[10], close_cmd_o}), 16'h0001);
		opc_operator_i.press(0, 10);
		@(posedge ref_clk_i) cold_load_pickup_blocked_i <= 1'b0;
		clr_seen;
		opc_operator_i.press(1, 10);
		check(16'({seen[10], close_cmd_o, lockout_cmd_o}), 16'h0006);
		@(posedge ref_clk_i) rec_closed_i <= 1'b1;
		wt(8);
		check(16'({closed_led_o, open_led_o}), 16'h0002);
		opc_operator_i.press(0, 10);
		clr_seen;
		opc_operator_i.press(1, 10);
		check(16'({seen[10], close_cmd_o}), 16'h0000);
		@(posedge ref_clk_i) mech_fail_i <= 1'b1;
		@(posedge ref_clk_i) mech_fail_i <= 1'b0;
		wt(8);
		check(16'(mechanism_fault_indicator_o), 16'h0001);
		@(posedge ref_clk_i) rec_closed_i <= 1'b0;
		wt(8);
		check(16'(mechanism_fault_indicator_o), 16'h0000);
		@(posedge ref_clk_i) rec_closed_i <= 1'b1;
		clr_seen;
		opc_operator_i.press(5, 10);
		check(16'(edit_mode_o), 16'h0001);
		opc_operator_i.flip(3);
		opc_operator_i.flip(4);
		check(16'({edit_mode_o, seen[8:0]}), 16'h0008);
		opc_operator_i.press(5, 10);
		wt(EDIT + 10);
		check(16'(edit_mode_o), 16'h0000);
		opc_operator_i.press(5, LONG + 4);
		check(16'({lamp_test_o, screen_o}), 16'h0044);
		clr_seen;
		opc_operator_i.press(2, 10);
		opc_operator_i.press(0, 10);
		check(16'({seen[9], screen_o}), 16'h0044);
		for (i = 0; i < 400 && lamp_test_o !== 1'b0; i = i + 1)
			wt(1);
		if (lamp_test_o !== 1'b0) begin
			mismatches = mismatches + 1;
			finish_test;
		end
		wt(8);
		check(16'({flashes[3:0], health_led_o, pickup_led_o}), 16'h000E);
		@(posedge ref_clk_i) ac_sense_i <= 1'b0;
		wt(MAINS - 10);
		check(16'(mains_indicator_o), 16'h0001);
		wt(20);
		check(16'(mains_indicator_o), 16'h0000);
		@(posedge ref_clk_i) ac_sense_i <= 1'b1;
		batt_mv_i <= 16'h4A38;
		wt(8);
		check(16'({mains_indicator_o, batt_led_o}), 16'h0003);
		@(posedge ref_clk_i) batt_mv_i <= 16'h4E20;
		wt(4);
		check(16'(batt_led_o), 16'h0000);
		@(posedge ref_clk_i) batt_test_drop_i <= 1'b1;
		wt(4);
		check(16'(batt_led_o), 16'h0001);
		@(posedge ref_clk_i) batt_test_drop_i <= 1'b0;
		@(posedge ref_clk_i) batt_test_done_i <= 1'b1;
		@(posedge ref_clk_i) batt_test_done_i <= 1'b0;
		wt(4);
		check(16'(batt_led_o), 16'h0001);
		@(posedge ref_clk_i) batt_test_done_i <= 1'b1;
		batt_test_pass_i <= 1'b1;
		@(posedge ref_clk_i) batt_test_done_i <= 1'b0;
		wt(4);
		check(16'(batt_led_o), 16'h0000);
		opc_operator_i.press(6, 10);
		wt(IDLE + 20);
		check(16'({backlight_o, health_led_o, tag_led_o, closed_led_o}), 16'h0003);
		opc_operator_i.press(3, 10);
		check(16'({backlight_o, health_led_o}), 16'h0003);
		finish_test;
	end
endmodule
